// [dv/tb_top.sv]
// bench for the watchdog counter
`timescale 1ns/1ps
module tb_top
	import wdog_pkg::*;
;
	logic mclk = 1'h0, rst = 1'h1, hw_activation = 1'h0, ext_stop_gating = 1'h0;
	logic wr = 1'h0, rd = 1'h0, stop_exec = 1'h0, wake = 1'h0, nmi_pin = 1'h0;
	logic wdog_reset, stop_granted, counter_frozen;
	logic [7:0] addr = 8'hD8, wdata = 8'h00, rdata;
	int n_mismatch = 0, tests_run = 0, n;
	// written value, then value read back
	logic [15:0] rows [4] = '{16'hFEFE, 16'h0606, 16'hA6A6, 16'h0202};
	wdog_counter i_dut (.mclk, .rst, .hw_activation, .ext_stop_gating, .addr, .wdata, .wr,
		.rd, .rdata, .stop_exec, .wake, .nmi_pin, .wdog_reset, .stop_granted, .counter_frozen);
	initial begin
		forever #10 mclk = ~mclk;
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task do_wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge mclk);
		wr <= 1'h0;
	endtask : do_wr
	task do_rd(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk);
		rd <= 1'h0;
		// data launched at the previous edge still stand here
		@(posedge mclk);
		chk(rdata, e);
	endtask : do_rd
	task do_reset;
		rst <= 1'h1;
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		repeat (2) @(posedge mclk);
	endtask : do_reset
	// one-cycle stop or wake pulse, then the stop flag
	task stop_chk(input logic w, input logic e);
		stop_exec <= !w;
		wake <= w;
		@(posedge mclk);
		stop_exec <= 1'h0;
		wake <= 1'h0;
		repeat (4) @(posedge mclk);
		chk({6'h00, counter_frozen, stop_granted}, {6'h00, e, e});
	endtask : stop_chk
	task print_verdict;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		do_reset();
		do_rd(ctrl_addr, ctrl_reset_val);
		do_rd(8'hD7, 8'h00);
		// unarmed: stop is really entered, wake leaves it
		stop_chk(1'h0, 1'h1);
		stop_chk(1'h1, 1'h0);
		foreach (rows[i]) begin
			do_wr(ctrl_addr, rows[i][15:8]);
			do_rd(ctrl_addr, rows[i][7:0]);
		end
		// unarmed: one tick takes the counter from 40h to 3Fh
		repeat (tick_cycles) @(posedge mclk);
		do_rd(ctrl_addr, 8'hFC);
		wdata <= 8'hFE;
		wr <= 1'h1;
		@(posedge mclk);
		wdata <= 8'hFC;
		@(posedge mclk);
		wr <= 1'h0;
		@(posedge mclk);
		chk({7'h00, wdog_reset}, 8'h01);
		do_wr(ctrl_addr, 8'h03);
		do_rd(ctrl_addr, 8'h03);
		do_wr(ctrl_addr, 8'h02);
		do_rd(ctrl_addr, 8'h03);
		n = 0;
		while (wdog_reset !== 1'h1 && n < 40000) begin
			@(posedge mclk);
			n++;
		end
		chk({7'h00, n > tick_cycles - 9 && n < tick_cycles + 9}, 8'h01);
		if (n < 40000) begin
			hw_activation <= 1'h1;
			do_reset();
			do_wr(ctrl_addr, 8'hFE);
			do_rd(ctrl_addr, 8'hFF);
			stop_chk(1'h0, 1'h0);
			stop_chk(1'h1, 1'h0);
			ext_stop_gating <= 1'h1;
			nmi_pin <= 1'h1;
			do_reset();
			stop_chk(1'h0, 1'h1);
			stop_chk(1'h1, 1'h0);
		end
		print_verdict();
	end
endmodule : tb_top

// [dv/wdog_counter_monitor.sv]
// port assertions for the watchdog counter
`timescale 1ns/1ps
module wdog_counter_monitor
	import wdog_pkg::*;
(
	// watched ports
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       hw_activation,
	input wire logic       ext_stop_gating,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       wake,
	input wire logic       wdog_reset,
	input wire logic       stop_granted,
	input wire logic       counter_frozen
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_set; wr && addr == ctrl_addr && wdata[1]; endsequence
	sequence s_clr; wr && addr == ctrl_addr && !wdata[1]; endsequence
	chk_sr_clear_fires: assert property (s_set ##1 s_clr |=> wdog_reset)
		else $error("no soft reset");
	chk_reset_one_cycle: assert property (wdog_reset |=> !wdog_reset)
		else $error("long reset pulse");
	chk_read_back: assert property (s_set ##1 rd && addr == ctrl_addr |=>
		rdata[7:1] == $past(wdata[7:1], 2))
		else $error("bad read back");
	chk_unmapped_zero: assert property (rd && addr != ctrl_addr |=> rdata == 8'h00)
		else $error("unmapped not zero");
	chk_rdata_holds: assert property (!rd |=> $stable(rdata))
		else $error("read data moved");
	chk_hw_arm_set: assert property (rd && addr == ctrl_addr && hw_activation |=> rdata[0])
		else $error("arm bit low");
	chk_hw_no_stop: assert property (hw_activation && !ext_stop_gating |-> !stop_granted)
		else $error("stop in hw mode");
	chk_wake_resumes: assert property (stop_granted && wake |=> !stop_granted && !counter_frozen)
		else $error("no resume");
endmodule : wdog_counter_monitor

bind wdog_counter wdog_counter_monitor i_mon (.*);

// [src/wdog_counter.sv]
// watchdog down counter with control register and stop handling
//
// How it works
// - reset loads register FEh: period and soft reset set, arm clear.
// - soft_reset_flag falling to zero on a tick raises a reset only when armed; a software write clearing it fires even unarmed.
// - register bit 7 is counter lsb, bit 2 the top period bit.
// - six period bits give 64 timeouts, 3072 to 196608 oscillator cycles.
// - unarmed, the counter still runs as a 7-bit timer.
// - hardware activation forces the arm bit to one, writes ignored.
// - software activation: writing one arms; only reset clears it.
// - register sits at data address D8h, read and write.
// - at least 28 instructions run after activation before a reset.
// - hardware activation without stop control: stop acts as wait.
// - stop control: stop with nmi high freezes counter until wake.
`timescale 1ns/1ps
module wdog_counter
	import wdog_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// factory options
	input  wire logic       hw_activation,
	input  wire logic       ext_stop_gating,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// core power control
	input  wire logic       stop_exec,
	input  wire logic       wake,
	input  wire logic       nmi_pin,
	// outputs
	output logic            wdog_reset,
	output logic            stop_granted,
	output logic            counter_frozen
);

	// ************************************
	// state
	// ************************************
	typedef struct packed {
		logic [cnt_w-1:0] cnt;
		logic             arm;
		logic [7:0]       rdata;
		logic             fire;
		pwr_state_t       pwr;
		logic             nmi_s1;
		logic             nmi_s2;
		logic             opt_hw;
		logic             opt_ext;
		logic             opt_done;
	} wd_state_t;

	wd_state_t st_reg;
	wd_state_t st_next;
	logic      tick;
	logic      reload;
	logic      armed;
	logic [7:0] reg_view;
	logic [cnt_w-1:0] wr_cnt;

	// ************************************
	// helpers
	// ************************************
	assign reload = wr && (addr == ctrl_addr);
	assign armed  = st_reg.arm || st_reg.opt_hw;

	// register bits 7..2 reversed onto counter bits 0..5, bit 1 onto bit 6
	genvar gi;
	for (gi = 0; gi < cnt_w - 1; gi++) begin : g_map
		assign reg_view[period_hi_pos - gi] = st_reg.cnt[gi];
		assign wr_cnt[gi] = wdata[period_hi_pos - gi];
	end
	assign reg_view[sr_pos]  = st_reg.cnt[cnt_w-1];
	assign reg_view[arm_pos] = armed;
	assign wr_cnt[cnt_w-1]   = wdata[sr_pos];

	// prescaler restarts on reload so the first tick is a full period;
	// with 3072-cycle ticks far more than 28 instructions fit before firing
	wdog_prescaler u_pre (
		.mclk    (mclk),
		.rst     (rst),
		.restart (reload),
		.freeze  (st_reg.pwr == st_stop),
		.tick    (tick)
	);

	// ************************************
	// next state
	// ************************************
	always_comb begin
		st_next        = st_reg;
		st_next.nmi_s1 = nmi_pin;
		st_next.nmi_s2 = st_reg.nmi_s1;
		st_next.fire   = 1'b0;
		// options are straps, caught once after reset release
		if (!st_reg.opt_done) begin
			st_next.opt_hw   = hw_activation;
			st_next.opt_ext  = ext_stop_gating;
			st_next.opt_done = 1'b1;
		end
		if (reload) begin
			st_next.cnt = wr_cnt;
			if (wdata[arm_pos]) begin
				st_next.arm = 1'b1;
			end
			// writing soft_reset_flag from one to zero fires at once
			if (st_reg.cnt[cnt_w-1] && !wdata[sr_pos]) begin
				st_next.fire = 1'b1;
			end
		end else if (tick) begin
			// runs even unarmed, as a plain timer
			st_next.cnt = st_reg.cnt - 1'b1;
			if (st_reg.cnt == {1'b1, {(cnt_w-1){1'b0}}} && armed) begin
				st_next.fire = 1'b1;
			end
		end
		case (st_reg.pwr)
			st_run: begin
				if (stop_exec) begin
					if (!armed) begin
						st_next.pwr = st_stop;
					end else if (st_reg.opt_ext && st_reg.nmi_s2) begin
						st_next.pwr = st_stop;
					end else begin
						st_next.pwr = st_wait;
					end
				end
			end
			st_wait: begin
				if (wake) begin
					st_next.pwr = st_run;
				end
			end
			st_stop: begin
				if (wake) begin
					st_next.pwr = st_run;
				end
			end
			default: begin
				st_next.pwr = st_run;
			end
		endcase
		st_next.rdata = rd ? ((addr == ctrl_addr) ? reg_view : 8'h00) : st_reg.rdata;
	end

	// ************************************
	// registers
	// ************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg          <= '0;
			st_reg.cnt      <= ctrl_reset_val[7:1];
			st_reg.arm      <= 1'b0;
			st_reg.pwr      <= st_run;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata          = st_reg.rdata;
	assign wdog_reset     = st_reg.fire;
	assign stop_granted   = (st_reg.pwr == st_stop);
	assign counter_frozen = (st_reg.pwr == st_stop);

endmodule : wdog_counter

// [src/wdog_pkg.sv]
// constants and types shared by the watchdog down counter
package wdog_pkg;

	// ************************************
	// register map
	// ************************************
	localparam logic [7:0] ctrl_addr      = 8'hD8;
	localparam logic [7:0] ctrl_reset_val = 8'hFE;
	localparam int         arm_pos        = 0;
	localparam int         sr_pos         = 1;
	localparam int         period_lo_pos  = 2;
	localparam int         period_hi_pos  = 7;

	// ************************************
	// timing
	// ************************************
	localparam int         osc_per_tick   = 3072;
	localparam int         mclk_mhz       = 50;
	localparam int         osc_mhz        = 8;
	localparam int         tick_cycles    = osc_per_tick * mclk_mhz / osc_mhz;
	localparam int         pre_w          = 15;
	localparam logic [pre_w-1:0] tick_last = pre_w'(tick_cycles - 1);
	localparam int         cnt_w          = 7;

	// ************************************
	// stop handling
	// ************************************
	typedef enum logic [1:0] {
		st_run  = 2'b00,
		st_wait = 2'b01,
		st_stop = 2'b11
	} pwr_state_t;

endpackage : wdog_pkg

// [src/wdog_prescaler.sv]
// prescaler that emits one tick per counter period
`timescale 1ns/1ps
module wdog_prescaler
	import wdog_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// control
	input  wire logic       restart,
	input  wire logic       freeze,
	// tick out
	output logic            tick
);

	typedef struct packed {
		logic [pre_w-1:0] cnt;
		logic             tick;
	} pre_state_t;

	pre_state_t st_reg;
	pre_state_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.tick = 1'b0;
		if (restart) begin
			st_next.cnt = '0;
		end else if (!freeze) begin
			if (st_reg.cnt == tick_last) begin
				st_next.cnt  = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

endmodule : wdog_prescaler
